// ==== mrt_pkg.sv ====
// Package of constants, codes and helpers for the memory range type resolver.
package mrt_pkg;
  // Memory type codes accepted by range typing.
  localparam logic [7:0] MRT_UC = 8'h00;
  localparam logic [7:0] MRT_WC = 8'h01;
  localparam logic [7:0] MRT_WT = 8'h04;
  localparam logic [7:0] MRT_WP = 8'h05;
  localparam logic [7:0] MRT_WB = 8'h06;
  // Register indices on the model-specific register port.
  localparam logic [7:0] MRT_IDX_CAP  = 8'h00;
  localparam logic [7:0] MRT_IDX_DEF  = 8'h01;
  localparam logic [7:0] MRT_IDX_VAR0 = 8'h10;
  // Field positions.
  localparam int MRT_TYPE_LSB  = 0;
  localparam int MRT_TYPE_MSB  = 7;
  localparam int MRT_ADDR_LSB  = 12;
  localparam int MRT_ADDR_MSB  = 51;
  localparam int MRT_ADDR_W    = 40;
  localparam int MRT_VALID_BIT = 11;
  localparam int MRT_FE_BIT    = 10;
  localparam int MRT_EN_BIT    = 11;
  localparam int MRT_CAP_FIX   = 8;
  localparam int MRT_CAP_WC    = 10;
  localparam int MRT_FEAT_BIT  = 12;
  // Reset values.
  localparam logic [7:0]  MRT_RST_TYPE = 8'h00;
  localparam logic [39:0] MRT_RST_ADDR = 40'h0;
  // Lookup latency in clock cycles from request to answer.
  localparam int MRT_LATENCY = 2;

  // True when a code is one of the basic types this device supports.
  function automatic logic mrt_code_ok(input logic [7:0] code, input logic wc_ok);
    logic ok;
    ok = (code == MRT_UC) || (code == MRT_WT) || (code == MRT_WP) || (code == MRT_WB);
    return ok || ((code == MRT_WC) && wc_ok);
  endfunction
endpackage

// ==== mrt_match_if.sv ====
// Interface carrying one base/mask pair to its matcher and the hit back.
`timescale 1ns/100ps
`default_nettype none
interface mrt_match_if;
  logic [39:0] base;   // Base field of the pair.
  logic [39:0] mask;   // Mask field of the pair.
  logic        pvalid; // Pair valid flag.
  logic [7:0]  ptype;  // Type code of the pair.
  logic [39:0] addr;   // Target address bits 51 to 12.
  logic        hit;    // Registered hit result.
  logic [7:0]  htype;  // Registered type of the hit.
  modport owner (output base, mask, pvalid, ptype, addr, input hit, htype);
  modport matcher (input base, mask, pvalid, ptype, addr, output hit, htype);
endinterface
`default_nettype wire

// ==== mrt_range_match.sv ====
// One variable range matcher with a registered hit.
`timescale 1ns/100ps
`default_nettype none
module mrt_range_match
  import mrt_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     rst_b_in,
  mrt_match_if.matcher  mi
);
  logic hit_ff;       // Registered hit.
  logic [7:0] typ_ff; // Registered type.
  logic nxt_hit;      // Combinational hit.

  // A pair with its valid flag clear never hits.
  assign nxt_hit = mi.pvalid && ((mi.mask & mi.base) == (mi.mask & mi.addr));

  // Register the result so the compare tree does not sit in the resolve path.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      hit_ff <= 1'b0;
      typ_ff <= MRT_RST_TYPE;
    end else begin
      hit_ff <= nxt_hit;
      typ_ff <= mi.ptype;
    end
  end

  assign mi.hit   = hit_ff;
  assign mi.htype = typ_ff;

  chk_match_hit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    mi.pvalid && ((mi.mask & mi.base) == (mi.mask & mi.addr)) |=> mi.hit)
    else $error("Matching range did not hit.");
  chk_invalid_pair: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !mi.pvalid |=> !mi.hit)
    else $error("Invalid pair produced a hit.");
endmodule // mrt_range_match
`default_nettype wire

// ==== mrt_page_combine.sv ====
// Combines the range type with the page cache bits into the effective type.
`timescale 1ns/100ps
`default_nettype none
module mrt_page_combine
  import mrt_pkg::*;
(
  input  wire logic [7:0] rng_type_in,
  input  wire logic       pcd_in,
  input  wire logic       pwt_in,
  input  wire logic       cache_off_in,
  output logic [7:0]      eff_type_out
);
  // Page bits only ever narrow the range type, never widen it.
  always_comb begin
    eff_type_out = rng_type_in;
    if (cache_off_in) begin
      // Caching globally off: nothing is cached.
      eff_type_out = MRT_UC;
    end else if (rng_type_in == MRT_WC) begin
      // Cache disable with writethrough clear keeps write-combining.
      if (pcd_in && pwt_in) begin
        eff_type_out = MRT_UC;
      end
    end else if (pcd_in) begin
      eff_type_out = MRT_UC;
    end else if (pwt_in && (rng_type_in == MRT_WB)) begin
      eff_type_out = MRT_WT;
    end
  end
endmodule // mrt_page_combine
`default_nettype wire

// ==== mrt_resolver.sv ====
// Top of the memory range type resolver: registers, matchers and resolve.
//
// Overview of operation
// - Range base holds type code; basic codes only.
// - Base field bits 51..12, low bits zero.
// - Mask bit 11 valid; invalid pair ignored.
// - Mask field bits 51..12, 4-Kbyte aligned.
// - Hit when mask-and-base equals mask-and-address.
// - Unmapped addresses take default type field.
// - Fixed enable gates fixed ranges only.
// - Master enable clear forces uncacheable.
// - Feature query reports support at bit 12.
// - Capability writes fault, contents kept.
// - Capability low byte counts variable pairs.
// - Capability bit 8 reports fixed ranges.
// - Capability bit 10 reports write-combining.
// - Page bits clear: range type applies.
// - Page cache-disable set gives uncacheable except write-combining.
// - Writethrough page turns writeback into writethrough.
// - Write-combining kept unless both page bits.
// - Fixed range beats variable range.
// - Overlap: same, uncacheable, writethrough-over-writeback.
// - Type codes 00,01,04,05,06 decoded.
`timescale 1ns/100ps
`default_nettype none
module mrt_resolver
  import mrt_pkg::*;
#(
  parameter int   PAIRS        = 8,    // Variable pairs, at most eight.
  parameter logic FIXED_SUPPORT = 1'b1, // Fixed ranges implemented.
  parameter logic WC_SUPPORT    = 1'b1  // Write-combining supported.
)(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        msr_wr_in,
  input  wire logic        msr_rd_in,
  input  wire logic [7:0]  msr_idx_in,
  input  wire logic [63:0] msr_wdata_in,
  output logic      [63:0] msr_rdata_out,
  output logic             msr_ack_out,
  output logic             msr_gp_out,
  input  wire logic        req_valid_in,
  input  wire logic [51:0] req_addr_in,
  input  wire logic        req_pcd_in,
  input  wire logic        req_pwt_in,
  input  wire logic        cache_off_in,
  input  wire logic        fixed_hit_in,
  input  wire logic [7:0]  fixed_type_in,
  output logic             eff_valid_out,
  output logic [7:0]       eff_type_out,
  output logic [31:0]      feature_edx_out
);

  // Variable pair storage.
  logic [39:0] base_ff  [PAIRS]; // Base fields.
  logic [7:0]  btype_ff [PAIRS]; // Type fields.
  logic [39:0] mask_ff  [PAIRS]; // Mask fields.
  logic        mval_ff  [PAIRS]; // Pair valid flags.
  // Default type control state.
  logic [7:0]  def_type_ff; // Default type.
  logic        fe_ff;       // Fixed ranges on.
  logic        en_ff;       // Master enable.
  // Register port answer.
  logic [63:0] rdata_ff; // Read data.
  logic        ack_ff;   // Access answered.
  logic        gp_ff;    // Access faulted.
  // Lookup stage one.
  logic        s1_val_ff;   // Request in stage one.
  logic        s1_pcd_ff;   // Page cache-disable bit.
  logic        s1_pwt_ff;   // Page writethrough bit.
  logic        s1_cd_ff;    // Global cache disable.
  logic        s1_en_ff;    // Master enable at request.
  logic        s1_fe_ff;    // Fixed enable at request.
  logic        s1_fhit_ff;  // Fixed range hit.
  logic [7:0]  s1_ftype_ff; // Fixed range type.
  logic [7:0]  s1_def_ff;   // Default type at request.
  // Lookup stage two, the answer.
  logic        eff_val_ff;  // Answer valid.
  logic [7:0]  eff_type_ff; // Effective type.
  logic [31:0] feat_ff;     // Feature query bits.
  // Decode and resolve nets.
  logic [PAIRS-1:0] hit_v;        // Hits of all pairs.
  logic [7:0]       htype_a [PAIRS]; // Types of all pairs.
  logic [2:0]       sel;          // Pair addressed.
  logic             is_var;       // Index is a pair register.
  logic             is_mask;      // Odd index is the mask half.
  logic [7:0]       wcode;        // Written type code.
  logic             code_ok;      // Written code supported.
  logic             f_uc, f_wc, f_wt, f_wp, f_wb; // Types among hits.
  logic [7:0]       rng_type;     // Range-derived type.
  logic [7:0]       nxt_eff;      // Effective type before register.
  logic [63:0]      cap_word;     // Capability contents.

  // Pair registers sit two per pair above the first pair index.
  assign is_var  = (msr_idx_in >= MRT_IDX_VAR0) &&
                   (msr_idx_in < MRT_IDX_VAR0 + 8'(2 * PAIRS));
  assign sel     = msr_idx_in[3:1];
  assign is_mask = msr_idx_in[0];
  assign wcode   = msr_wdata_in[MRT_TYPE_MSB:MRT_TYPE_LSB];
  assign code_ok = mrt_code_ok(wcode, WC_SUPPORT);

  // Capability word is built from parameters, never from state.
  always_comb begin
    cap_word = 64'h0;
    cap_word[7:0] = 8'(PAIRS);
    cap_word[MRT_CAP_FIX] = FIXED_SUPPORT;
    cap_word[MRT_CAP_WC] = WC_SUPPORT;
  end

  // Pair registers take writes; a bad type code faults and stores nothing.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < PAIRS; i++) begin
        base_ff[i]  <= MRT_RST_ADDR;
        btype_ff[i] <= MRT_RST_TYPE;
        mask_ff[i]  <= MRT_RST_ADDR;
        mval_ff[i]  <= 1'b0;
      end
    end else if (msr_wr_in && is_var) begin
      if (is_mask) begin
        mask_ff[sel] <= msr_wdata_in[MRT_ADDR_MSB:MRT_ADDR_LSB];
        mval_ff[sel] <= msr_wdata_in[MRT_VALID_BIT];
      end else if (code_ok) begin
        base_ff[sel]  <= msr_wdata_in[MRT_ADDR_MSB:MRT_ADDR_LSB];
        btype_ff[sel] <= wcode;
      end
    end
  end

  // Default type control takes writes with the same code check.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      def_type_ff <= MRT_RST_TYPE;
      fe_ff       <= 1'b0;
      en_ff       <= 1'b0;
    end else if (msr_wr_in && (msr_idx_in == MRT_IDX_DEF) && code_ok) begin
      def_type_ff <= wcode;
      fe_ff       <= msr_wdata_in[MRT_FE_BIT];
      en_ff       <= msr_wdata_in[MRT_EN_BIT];
    end
  end

  // Every access is answered one cycle later; a write wins over a read.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_ff   <= 1'b0;
      gp_ff    <= 1'b0;
      rdata_ff <= 64'h0;
    end else begin
      ack_ff <= msr_wr_in || msr_rd_in;
      gp_ff  <= 1'b0;
      if (msr_wr_in) begin
        // Capability is read-only; unknown indices fault too.
        if (msr_idx_in == MRT_IDX_CAP) begin
          gp_ff <= 1'b1;
        end else if (msr_idx_in == MRT_IDX_DEF) begin
          gp_ff <= !code_ok;
        end else if (is_var) begin
          gp_ff <= !is_mask && !code_ok;
        end else begin
          gp_ff <= 1'b1;
        end
      end else if (msr_rd_in) begin
        if (msr_idx_in == MRT_IDX_CAP) begin
          rdata_ff <= cap_word;
        end else if (msr_idx_in == MRT_IDX_DEF) begin
          rdata_ff <= {52'h0, en_ff, fe_ff, 2'b00, def_type_ff};
        end else if (is_var && is_mask) begin
          rdata_ff <= {12'h0, mask_ff[sel], mval_ff[sel], 11'h0};
        end else if (is_var) begin
          rdata_ff <= {12'h0, base_ff[sel], 4'h0, btype_ff[sel]};
        end else begin
          rdata_ff <= 64'h0;
          gp_ff    <= 1'b1;
        end
      end
    end
  end

  // One matcher per pair; each registers its hit at the request edge.
  generate
    for (genvar g = 0; g < PAIRS; g++) begin : g_pair
      mrt_match_if mi ();
      assign mi.base   = base_ff[g];
      assign mi.mask   = mask_ff[g];
      assign mi.pvalid = mval_ff[g];
      assign mi.ptype  = btype_ff[g];
      assign mi.addr   = req_addr_in[MRT_ADDR_MSB:MRT_ADDR_LSB];
      assign hit_v[g]   = mi.hit;
      assign htype_a[g] = mi.htype;
      mrt_range_match u_match (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .mi       (mi)
      );
    end
  endgenerate

  // Stage one captures the request's side inputs beside the matchers.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s1_val_ff   <= 1'b0;
      s1_pcd_ff   <= 1'b0;
      s1_pwt_ff   <= 1'b0;
      s1_cd_ff    <= 1'b0;
      s1_en_ff    <= 1'b0;
      s1_fe_ff    <= 1'b0;
      s1_fhit_ff  <= 1'b0;
      s1_ftype_ff <= MRT_RST_TYPE;
      s1_def_ff   <= MRT_RST_TYPE;
    end else begin
      s1_val_ff   <= req_valid_in;
      s1_pcd_ff   <= req_pcd_in;
      s1_pwt_ff   <= req_pwt_in;
      s1_cd_ff    <= cache_off_in;
      s1_en_ff    <= en_ff;
      s1_fe_ff    <= fe_ff;
      s1_fhit_ff  <= fixed_hit_in;
      s1_ftype_ff <= fixed_type_in;
      s1_def_ff   <= def_type_ff;
    end
  end

  // Gather which types the hitting pairs carry.
  always_comb begin
    f_uc = 1'b0;
    f_wc = 1'b0;
    f_wt = 1'b0;
    f_wp = 1'b0;
    f_wb = 1'b0;
    for (int i = 0; i < PAIRS; i++) begin
      if (hit_v[i]) begin
        f_uc = f_uc || (htype_a[i] == MRT_UC);
        f_wc = f_wc || (htype_a[i] == MRT_WC);
        f_wt = f_wt || (htype_a[i] == MRT_WT);
        f_wp = f_wp || (htype_a[i] == MRT_WP);
        f_wb = f_wb || (htype_a[i] == MRT_WB);
      end
    end
  end

  // Resolve the range type; undefined overlaps fall to uncacheable as the safe choice.
  always_comb begin
    if (!s1_en_ff) begin
      rng_type = MRT_UC;
    end else if (s1_fe_ff && s1_fhit_ff) begin
      rng_type = s1_ftype_ff;
    end else if (hit_v == '0) begin
      rng_type = s1_def_ff;
    end else if (f_uc) begin
      rng_type = MRT_UC;
    end else if ($onehot({f_wc, f_wt, f_wp, f_wb})) begin
      rng_type = f_wc ? MRT_WC : f_wt ? MRT_WT : f_wp ? MRT_WP : MRT_WB;
    end else if (f_wt && f_wb && !f_wc && !f_wp) begin
      rng_type = MRT_WT;
    end else begin
      rng_type = MRT_UC;
    end
  end

  // Page bits narrow the range type.
  mrt_page_combine u_comb (
    .rng_type_in  (rng_type),
    .pcd_in       (s1_pcd_ff),
    .pwt_in       (s1_pwt_ff),
    .cache_off_in (s1_cd_ff),
    .eff_type_out (nxt_eff)
  );

  // Stage two registers the answer, giving a fixed latency.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      eff_val_ff  <= 1'b0;
      eff_type_ff <= MRT_UC;
    end else begin
      eff_val_ff  <= s1_val_ff;
      eff_type_ff <= nxt_eff;
    end
  end

  // Feature bit is constant once out of reset.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      feat_ff <= 32'h0;
    end else begin
      feat_ff <= 32'h0;
      feat_ff[MRT_FEAT_BIT] <= 1'b1;
    end
  end

  assign msr_rdata_out   = rdata_ff;
  assign msr_ack_out     = ack_ff;
  assign msr_gp_out      = gp_ff;
  assign eff_valid_out   = eff_val_ff;
  assign eff_type_out    = eff_type_ff;
  assign feature_edx_out = feat_ff;

  // A request is followed by its answer two edges later.
  sequence s_req;
    req_valid_in;
  endsequence
  chk_lat_valid: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_req |-> ##1 s1_val_ff ##1 eff_valid_out)
    else $error("Answer not two cycles after request.");
  chk_off_uc: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    req_valid_in && !en_ff |-> ##2 eff_type_out == MRT_UC)
    else $error("Disabled ranges did not give uncacheable.");
  chk_cap_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    msr_wr_in && msr_idx_in == MRT_IDX_CAP |=> msr_ack_out && msr_gp_out)
    else $error("Capability write did not fault.");
  chk_cap_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    msr_rd_in && !msr_wr_in && msr_idx_in == MRT_IDX_CAP |=> msr_rdata_out[7:0] == 8'(PAIRS))
    else $error("Capability count wrong.");
  chk_bad_base: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    msr_wr_in && is_var && !is_mask && !code_ok |=> msr_gp_out && (btype_ff[$past(sel)] != $past(wcode)))
    else $error("Bad base type accepted.");
  chk_bad_def: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    msr_wr_in && msr_idx_in == MRT_IDX_DEF && !code_ok |=> msr_gp_out && $stable(def_type_ff))
    else $error("Bad default type accepted.");
  chk_pcd_uc: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s1_val_ff && s1_pcd_ff && rng_type != MRT_WC |=> eff_type_out == MRT_UC)
    else $error("Cache-disable page not uncacheable.");
  chk_wb_to_wt: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s1_val_ff && !s1_cd_ff && !s1_pcd_ff && s1_pwt_ff && rng_type == MRT_WB
    |=> eff_type_out == MRT_WT)
    else $error("Writeback under writethrough page not writethrough.");
  chk_plain_page: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s1_val_ff && !s1_cd_ff && !s1_pcd_ff && !s1_pwt_ff |=> eff_type_out == $past(rng_type))
    else $error("Plain page changed the range type.");
  chk_wc_both: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s1_val_ff && !s1_cd_ff && rng_type == MRT_WC && s1_pcd_ff && s1_pwt_ff
    |=> eff_type_out == MRT_UC)
    else $error("Write-combining with both page bits not uncacheable.");
  chk_fixed_prio: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s1_en_ff && s1_fe_ff && s1_fhit_ff |-> rng_type == s1_ftype_ff)
    else $error("Fixed range lost priority.");
  chk_feature_bit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $past(rst_b_in) |-> feature_edx_out[MRT_FEAT_BIT])
    else $error("Feature bit not reported.");
endmodule // mrt_resolver
`default_nettype wire

// ==== mrt_lsu_model.sv ====
// Model of the load/store and paging side that issues type lookups.
`timescale 1ns/100ps
`default_nettype none
module mrt_lsu_model (
  input  wire logic       clk_in,
  input  wire logic       eff_valid_in,
  input  wire logic [7:0] eff_type_in,
  output logic            req_valid_out,
  output logic [51:0]     req_addr_out,
  output logic            req_pcd_out,
  output logic            req_pwt_out,
  output logic            cache_off_out,
  output logic            fixed_hit_out,
  output logic [7:0]      fixed_type_out
);
  // Quiet at time zero so nothing is taken during reset.
  initial begin
    req_valid_out  = 1'b0;
    req_addr_out   = 52'h0;
    req_pcd_out    = 1'b0;
    req_pwt_out    = 1'b0;
    cache_off_out  = 1'b0;
    fixed_hit_out  = 1'b0;
    fixed_type_out = 8'h00;
  end

  // One lookup of a 4-Kbyte page, so no large page can span mixed ranges.
  // The flags word f is {page cache-disable, page writethrough, cache off, fixed hit}.
  task automatic lookup(input logic [51:0] a, input logic [3:0] f, input logic [7:0] ft,
                        output logic early, output logic ok, output logic [7:0] typ);
    @(negedge clk_in);
    req_valid_out  <= 1'b1;
    req_addr_out   <= a;
    {req_pcd_out, req_pwt_out, cache_off_out, fixed_hit_out} <= f;
    fixed_type_out <= ft;
    @(negedge clk_in);
    // Half a cycle after the taking edge the answer must not be out yet.
    early = eff_valid_in;
    // Released lines carry the inverse, so a stale value cannot pass for a held one.
    req_valid_out  <= 1'b0;
    req_addr_out   <= ~a;
    {req_pcd_out, req_pwt_out, cache_off_out, fixed_hit_out} <= ~f;
    fixed_type_out <= ~ft;
    @(negedge clk_in);
    // The answer stands for the single cycle after the second edge.
    ok  = eff_valid_in;
    typ = eff_type_in;
  endtask
endmodule // mrt_lsu_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the memory range type resolver.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mrt_pkg::*;
  logic        clk_in;
  logic        rst_b_in;
  logic        msr_wr_in;
  logic        msr_rd_in;
  logic [7:0]  msr_idx_in;
  logic [63:0] msr_wdata_in;
  logic [63:0] msr_rdata_out;
  logic        msr_ack_out;
  logic        msr_gp_out;
  logic        req_valid_in;
  logic [51:0] req_addr_in;
  logic        req_pcd_in;
  logic        req_pwt_in;
  logic        cache_off_in;
  logic        fixed_hit_in;
  logic [7:0]  fixed_type_in;
  logic        eff_valid_out;
  logic [7:0]  eff_type_out;
  logic [31:0] feature_edx_out;
  logic [63:0] rd;     // Read data of the last register access.
  logic        gpf;    // Fault flag of the last register access.
  int          n_fail;
  int          n_compared;
  logic [7:0]  tlist [5] = '{MRT_UC, MRT_WC, MRT_WT, MRT_WP, MRT_WB};

  // Only one resolver exists here, so its settings are trivially consistent.
  mrt_resolver i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .msr_wr_in(msr_wr_in), .msr_rd_in(msr_rd_in),
    .msr_idx_in(msr_idx_in), .msr_wdata_in(msr_wdata_in), .msr_rdata_out(msr_rdata_out),
    .msr_ack_out(msr_ack_out), .msr_gp_out(msr_gp_out), .req_valid_in(req_valid_in),
    .req_addr_in(req_addr_in), .req_pcd_in(req_pcd_in), .req_pwt_in(req_pwt_in),
    .cache_off_in(cache_off_in), .fixed_hit_in(fixed_hit_in), .fixed_type_in(fixed_type_in),
    .eff_valid_out(eff_valid_out), .eff_type_out(eff_type_out),
    .feature_edx_out(feature_edx_out));

  mrt_lsu_model i_lsu (
    .clk_in(clk_in), .eff_valid_in(eff_valid_out), .eff_type_in(eff_type_out),
    .req_valid_out(req_valid_in), .req_addr_out(req_addr_in), .req_pcd_out(req_pcd_in),
    .req_pwt_out(req_pwt_in), .cache_off_out(cache_off_in), .fixed_hit_out(fixed_hit_in),
    .fixed_type_out(fixed_type_in));

  // The 10 MHz clock.
  always #50 clk_in = ~clk_in;

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One register access; the answer is sampled half a cycle after the taking edge.
  task automatic msr(input logic wr, input logic [7:0] idx, input logic [63:0] wd);
    @(negedge clk_in);
    msr_wr_in    <= wr;
    msr_rd_in    <= ~wr;
    msr_idx_in   <= idx;
    msr_wdata_in <= wd;
    @(negedge clk_in);
    // Acknowledge and fault stand for this one cycle only; read data holds until the next read.
    rd  = msr_rdata_out;
    gpf = msr_gp_out;
    chk_bit("msr_ack", 1'b1, msr_ack_out);
    msr_wr_in    <= 1'b0;
    msr_rd_in    <= 1'b0;
    msr_idx_in   <= ~idx;
    msr_wdata_in <= ~wd;
  endtask

  // One lookup through the model; the answer must come exactly two cycles on.
  task automatic lk(input string nm, input logic [51:0] a, input logic [3:0] f,
                    input logic [7:0] ft, input logic [7:0] e);
    logic       early;
    logic       ok;
    logic [7:0] typ;
    i_lsu.lookup(a, f, ft, early, ok, typ);
    chk_bit("eff_valid_early", 1'b0, early);
    chk_bit("eff_valid", 1'b1, ok);
    chk_word(nm, {56'h0, e}, {56'h0, typ});
  endtask

  // Effective type from the range type and the two page bits, caching on.
  function automatic logic [7:0] page_exp(input logic [7:0] t, input logic page_cache_disable_bit, input logic page_writethrough_bit);
    if (t == MRT_WC) return (page_cache_disable_bit && page_writethrough_bit) ? MRT_UC : MRT_WC;
    if (page_cache_disable_bit) return MRT_UC;
    if (page_writethrough_bit && (t == MRT_WB)) return MRT_WT;
    return t;
  endfunction

  // Reset contents, the feature bit and the read-only capability word.
  task automatic t_caps();
    chk_bit("feature_bit", 1'b1, feature_edx_out[MRT_FEAT_BIT]);
    msr(1'b0, MRT_IDX_CAP, 64'h0);
    chk_word("cap", 64'h508, rd);
    msr(1'b1, MRT_IDX_CAP, 64'h0);
    chk_bit("cap_wr_gp", 1'b1, gpf);
    msr(1'b0, MRT_IDX_CAP, 64'h0);
    chk_word("cap_kept", 64'h508, rd);
    msr(1'b0, 8'h0F, 64'h0);
    chk_bit("unknown_gp", 1'b1, gpf);
    msr(1'b0, MRT_IDX_DEF, 64'h0);
    chk_word("def_reset", 64'h0, rd);
  endtask

  // Master enable off overrides type and fixed hit; a bad default type is refused.
  task automatic t_enable();
    msr(1'b1, MRT_IDX_DEF, 64'h406);
    lk("off_type", 52'h123_4000, 4'b0001, MRT_WB, MRT_UC);
    msr(1'b1, MRT_IDX_DEF, 64'hC07);
    chk_bit("def_bad_gp", 1'b1, gpf);
    msr(1'b0, MRT_IDX_DEF, 64'h0);
    chk_word("def_kept", 64'h406, rd);
    msr(1'b1, MRT_IDX_DEF, 64'h804);
    lk("def_type", 52'h123_4000, 4'b0000, 8'h00, MRT_WT);
  endtask

  // A 32-Mbyte writeback range at 200_0000h, its upper edge, top address bit, valid flag and bad type.
  task automatic t_var();
    msr(1'b1, MRT_IDX_VAR0, 64'h0200_0006);
    msr(1'b1, MRT_IDX_VAR0 + 8'h01, 64'h000F_FFFF_FE00_0800);
    lk("in_range", 52'h2AB_C123, 4'b0000, 8'h00, MRT_WB);
    lk("above_range", 52'h400_0000, 4'b0000, 8'h00, MRT_WT);
    lk("top_bit", 52'h8_0000_0200_0000, 4'b0000, 8'h00, MRT_WT);
    msr(1'b1, MRT_IDX_VAR0, 64'h0200_0002);
    chk_bit("base_bad_gp", 1'b1, gpf);
    msr(1'b0, MRT_IDX_VAR0, 64'h0);
    chk_word("base_rd", 64'h0200_0006, rd);
    msr(1'b0, MRT_IDX_VAR0 + 8'h01, 64'h0);
    chk_word("mask_rd", 64'h000F_FFFF_FE00_0800, rd);
    lk("base_kept", 52'h200_0000, 4'b0000, 8'h00, MRT_WB);
    msr(1'b1, MRT_IDX_VAR0 + 8'h01, 64'h000F_FFFF_FE00_0000);
    lk("pair_off", 52'h200_0000, 4'b0000, 8'h00, MRT_WT);
    msr(1'b1, MRT_IDX_VAR0 + 8'h01, 64'h000F_FFFF_FE00_0800);
  endtask

  // A 4-Kbyte second range inside the first, with three type mixes.
  task automatic t_overlap();
    msr(1'b1, 8'h13, 64'h000F_FFFF_FFFF_F800);
    msr(1'b1, 8'h12, 64'h0200_3004);
    lk("wt_over_wb", 52'h200_3010, 4'b0000, 8'h00, MRT_WT);
    lk("wb_alone", 52'h200_4000, 4'b0000, 8'h00, MRT_WB);
    msr(1'b1, 8'h12, 64'h0200_3000);
    lk("uc_over_wb", 52'h200_3010, 4'b0000, 8'h00, MRT_UC);
    msr(1'b1, 8'h12, 64'h0200_3006);
    lk("same_type", 52'h200_3010, 4'b0000, 8'h00, MRT_WB);
  endtask

  // Fixed hit ignored with its enable clear, then wins; cache off gives uncacheable.
  task automatic t_fixed();
    lk("fe_clear", 52'h200_3010, 4'b0001, MRT_WP, MRT_WB);
    msr(1'b1, MRT_IDX_DEF, 64'hC04);
    lk("fixed_first", 52'h200_3010, 4'b0001, MRT_WP, MRT_WP);
    lk("cache_off", 52'h200_3010, 4'b0010, MRT_WP, MRT_UC);
  endtask

  // Every range type against every page bit pair, through the default type.
  task automatic t_page();
    for (int i = 0; i < 5; i++) begin
      msr(1'b1, MRT_IDX_DEF, {52'h0, 4'h8, tlist[i]});
      for (int p = 0; p < 4; p++) begin
        lk("page_type", 52'h900_0000, {p[1:0], 2'b00}, 8'h00, page_exp(tlist[i], p[1], p[0]));
      end
    end
  endtask

  task automatic finish_test();
    if ((n_fail == 0) && (n_compared > 0)) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The run needs about one hundred and sixty cycles; a hang is cut off well beyond.
  initial begin
    repeat (3000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end

  initial begin
    clk_in       = 1'b0;
    rst_b_in     = 1'b0;
    msr_wr_in    = 1'b0;
    msr_rd_in    = 1'b0;
    msr_idx_in   = 8'h00;
    msr_wdata_in = 64'h0;
    n_fail       = 0;
    n_compared   = 0;
    repeat (6) @(negedge clk_in);
    rst_b_in <= 1'b1;
    @(negedge clk_in);
    t_caps();
    t_enable();
    t_var();
    t_overlap();
    t_fixed();
    t_page();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
